/* verilog/cpwm_gen.sv */
// complementary pwm output generator with apb register access
// assumes event sources and limit timer arrive asynchronously; apb on I_CORE_CLK
//
// Notes on behaviour
// - generator clock chosen by 2-bit select: fast oscillator, clock/4 or clock.
// - generator clock times dead bands, blankings and phase delay.
// - rise and fall sources each have 3-bit select and own mode bit.
// - each event input is edge or level sensitive, independently.
// - same signal may feed both events; async sources are accepted.
// - rising event is low-to-high of rise source; starts active part.
// - falling event is high-to-low of fall source; ends active part.
// - rise: blank falls, phase delay, clear secondary, dead band, set primary.
// - zero phase and zero rise dead band set primary at once.
// - fall: clear primary, blank rises, fall dead band, then set secondary.
// - zero fall dead band sets secondary at once.
// - single source gives outputs matching input frequency and duty.
// - just after enabling, primary is cleared and secondary active.
// - each output has an enable; cleared means pin not driven.
// - output enables independent of module enable; disabled shows overrides.
// - per output polarity bit: set gives active low.
// - polarity applies to waveform only, never to override levels.
// - some event inputs are ored with the limit timer output.
// - rise and fall 4-bit dead bands share one counter of generator clocks; zero disables.
// - cross-coupled 4-bit blanking counters; zero lets events straight through.
// - zero phase passes rise through; else delay by that many periods.
//
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module cpwm_gen
	import cpwm_pkg::*;
#(
	parameter int unsigned FAST_DIV = FAST_OSC_DIV
) (
	input  wire logic              I_CORE_CLK,
	input  wire logic              I_RSTN,
	input  wire logic              I_PSEL,
	input  wire logic              I_PENABLE,
	input  wire logic              I_PWRITE,
	input  wire logic [7:0]        I_PADDR,
	input  wire logic [31:0]       I_PWDATA,
	output logic      [31:0]       O_PRDATA,
	output logic                   O_PREADY,
	output logic                   O_PSLVERR,
	input  wire logic [N_SRC-1:0]  I_EVENT_SRC,
	input  wire logic              I_LIMIT_TIMER,
	output logic                   O_PRIMARY_DRIVE_OUT,
	output logic                   O_PRIMARY_DRIVE_OE,
	output logic                   O_SECONDARY_DRIVE_OUT,
	output logic                   O_SECONDARY_DRIVE_OE
);

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		logic [C0_W-1:0]  ctl0;
		logic [C1_W-1:0]  ctl1;
		logic [NIB_W-1:0] db;
		logic [NIB_W-1:0] blk;
		logic [CNT_W-1:0] ph;
		logic [31:0]      prdata;
		logic             pready;
		logic             pslverr;
		logic [N_SRC:0]   sync1;
		logic [N_SRC:0]   sync2;
		logic             rise_prev;
		logic             fall_prev;
		logic [DIV_W-1:0] div;
		logic             tick;
		drive_state_e     st;
		logic [CNT_W-1:0] cnt;
		logic             rblk_on;
		logic [CNT_W-1:0] rblk_cnt;
		logic             fblk_on;
		logic [CNT_W-1:0] fblk_cnt;
		logic             en_prev;
		logic             pri_out;
		logic             pri_oe;
		logic             sec_out;
		logic             sec_oe;
	} state_s;

	state_s s_r;
	state_s s_nxt;

	// generator clock period in core cycles for a select code
	function automatic logic [DIV_W-1:0] gen_period(input logic [1:0] cs);
		logic [DIV_W-1:0] p;
		p = DIV_W'(SYS_DIV);
		unique case (cs)
			CS_FAST_OSC: p = DIV_W'(FAST_DIV);
			CS_INSTR:    p = DIV_W'(INSTR_DIV);
			default:     p = DIV_W'(SYS_DIV);
		endcase
		return p;
	endfunction : gen_period

	// source pick with limit timer ored onto the top two selects
	function automatic logic pick_src(input logic [N_SRC:0] v, input logic [SEL_W-1:0] sel);
		logic x;
		x = v[sel];
		if (sel == SRC_LIMIT_A || sel == SRC_LIMIT_B) begin
			x = x | v[N_SRC];
		end
		return x;
	endfunction : pick_src

	// ****************************************************************
	// next state
	// ****************************************************************
	logic             wr_acc;
	logic             rd_acc;
	logic             gen_en;
	logic [SEL_W-1:0] rsel;
	logic [SEL_W-1:0] fsel;
	logic             rsrc;
	logic             fsrc;
	logic             rise_ev;
	logic             fall_ev;
	logic             rise_side;
	logic [CNT_W-1:0] dbr;
	logic [CNT_W-1:0] dbf;
	logic [CNT_W-1:0] blkr;
	logic [CNT_W-1:0] blkf;
	logic             pri_act;
	logic             sec_act;
	logic             start_rblk;
	logic             start_fblk;
	logic             mapped;
	logic [31:0]      rd_val;

	always_comb begin
		s_nxt = s_r;
		gen_en = s_r.ctl0[C0_EN];
		rsel = s_r.ctl1[C1_RS_LO +: SEL_W];
		fsel = s_r.ctl1[C1_FS_LO +: SEL_W];
		dbr  = s_r.db[NIB_RISE_LO +: CNT_W];
		dbf  = s_r.db[NIB_FALL_LO +: CNT_W];
		blkr = s_r.blk[NIB_RISE_LO +: CNT_W];
		blkf = s_r.blk[NIB_FALL_LO +: CNT_W];
		start_rblk = 1'b0;
		start_fblk = 1'b0;

		// ---- apb: one wait state, answer registered ----
		wr_acc = I_PSEL & I_PENABLE & s_r.pready & I_PWRITE;
		rd_acc = I_PSEL & I_PENABLE & ~s_r.pready & ~I_PWRITE;
		mapped = 1'b1;
		rd_val = RD_ZERO;
		unique case (I_PADDR)
			OFS_CONTROL_0: rd_val[C0_W-1:0]  = s_r.ctl0;
			OFS_CONTROL_1: rd_val[C1_W-1:0]  = s_r.ctl1;
			OFS_DEADBAND:  rd_val[NIB_W-1:0] = s_r.db;
			OFS_BLANKING:  rd_val[NIB_W-1:0] = s_r.blk;
			OFS_PHASE:     rd_val[CNT_W-1:0] = s_r.ph;
			OFS_STATUS:    rd_val[6:0] = {s_r.fblk_on, s_r.rblk_on, s_r.sec_out ^
				s_r.ctl0[C0_POL1], s_r.pri_out ^ s_r.ctl0[C0_POL0], s_r.st};
			default:       mapped = 1'b0;
		endcase
		s_nxt.pready  = I_PSEL & I_PENABLE & ~s_r.pready;
		s_nxt.pslverr = I_PSEL & I_PENABLE & ~s_r.pready & ~mapped;
		if (rd_acc) begin
			s_nxt.prdata = rd_val;
		end
		if (wr_acc) begin
			unique case (I_PADDR)
				OFS_CONTROL_0: s_nxt.ctl0 = I_PWDATA[C0_W-1:0];
				OFS_CONTROL_1: s_nxt.ctl1 = I_PWDATA[C1_W-1:0];
				OFS_DEADBAND:  s_nxt.db   = I_PWDATA[NIB_W-1:0];
				OFS_BLANKING:  s_nxt.blk  = I_PWDATA[NIB_W-1:0];
				OFS_PHASE:     s_nxt.ph   = I_PWDATA[CNT_W-1:0];
				default:       s_nxt.ctl0 = s_r.ctl0;
			endcase
		end

		// ---- event inputs: two flops, async sources welcome ----
		s_nxt.sync1 = {I_LIMIT_TIMER, I_EVENT_SRC};
		s_nxt.sync2 = s_r.sync1;
		rsrc = pick_src(s_r.sync2, rsel);
		fsrc = pick_src(s_r.sync2, fsel);
		s_nxt.rise_prev = rsrc;
		s_nxt.fall_prev = fsrc;

		// ---- generator clock as a tick ----
		if (s_r.div >= gen_period(s_r.ctl0[C0_CS_LO +: 2]) - DIV_W'(1)) begin
			s_nxt.div  = '0;
			s_nxt.tick = 1'b1;
		end else begin
			s_nxt.div  = s_r.div + DIV_W'(1);
			s_nxt.tick = 1'b0;
		end

		// ---- event detection, edge or level per input ----
		rise_side = (s_r.st == ST_PHASE) || (s_r.st == ST_RISE_DB) || (s_r.st == ST_ON);
		rise_ev = (s_r.ctl1[C1_RSIM] ? rsrc : (rsrc & ~s_r.rise_prev))
			& ~s_r.fblk_on & ~rise_side;
		fall_ev = (s_r.ctl1[C1_FSIM] ? ~fsrc : (~fsrc & s_r.fall_prev))
			& ~s_r.rblk_on & rise_side;

		// ---- drive sequence ----
		if (s_r.tick) begin
			s_nxt.cnt = s_r.cnt + CNT_W'(1);
		end
		if (!gen_en) begin
			s_nxt.st = ST_OFF;
			s_nxt.cnt = '0;
		end else if (fall_ev) begin
			// fall during phase or rise dead band suppresses primary
			start_fblk = 1'b1;
			s_nxt.cnt = '0;
			s_nxt.st = (dbf == '0) ? ST_OFF : ST_FALL_DB;
		end else begin
			unique case (s_r.st)
				ST_OFF, ST_FALL_DB: begin
					// end only on a tick past the count: full periods, never short
					if (s_r.st == ST_FALL_DB && s_r.tick && s_r.cnt == dbf) begin
						s_nxt.st = ST_OFF;
						s_nxt.cnt = '0;
					end
					if (rise_ev) begin
						start_rblk = 1'b1;
						s_nxt.cnt = '0;
						if (s_r.ph != '0) begin
							s_nxt.st = ST_PHASE;
						end else if (dbr != '0) begin
							s_nxt.st = ST_RISE_DB;
						end else begin
							s_nxt.st = ST_ON;
						end
					end
				end
				ST_PHASE: begin
					if (s_r.tick && s_r.cnt == s_r.ph) begin
						s_nxt.cnt = '0;
						s_nxt.st = (dbr == '0) ? ST_ON : ST_RISE_DB;
					end
				end
				ST_RISE_DB: begin
					if (s_r.tick && s_r.cnt == dbr) begin
						s_nxt.st = ST_ON;
						s_nxt.cnt = '0;
					end
				end
				ST_ON: s_nxt.cnt = '0;
			endcase
		end

		// ---- blanking, cross coupled ----
		if (start_rblk) begin
			s_nxt.rblk_on = (blkr != '0);
			s_nxt.rblk_cnt = '0;
		end else if (s_r.rblk_on && s_r.tick) begin
			s_nxt.rblk_cnt = s_r.rblk_cnt + CNT_W'(1);
			s_nxt.rblk_on = (s_r.rblk_cnt + CNT_W'(1) != blkr);
		end
		if (start_fblk) begin
			s_nxt.fblk_on = (blkf != '0);
			s_nxt.fblk_cnt = '0;
		end else if (s_r.fblk_on && s_r.tick) begin
			s_nxt.fblk_cnt = s_r.fblk_cnt + CNT_W'(1);
			s_nxt.fblk_on = (s_r.fblk_cnt + CNT_W'(1) != blkf);
		end
		if (!gen_en) begin
			s_nxt.rblk_on = 1'b0;
			s_nxt.fblk_on = 1'b0;
		end

		// ---- output stage ----
		// computed from the next state so pins follow the sequence with one flop
		pri_act = (s_nxt.st == ST_ON);
		sec_act = (s_nxt.st == ST_OFF) || (s_nxt.st == ST_PHASE);
		s_nxt.en_prev = gen_en;
		if (s_nxt.ctl0[C0_EN]) begin
			s_nxt.pri_out = pri_act ^ s_nxt.ctl0[C0_POL0];
			s_nxt.sec_out = sec_act ^ s_nxt.ctl0[C0_POL1];
		end else begin
			// overrides bypass polarity
			s_nxt.pri_out = s_nxt.ctl0[C0_OVR0];
			s_nxt.sec_out = s_nxt.ctl0[C0_OVR1];
		end
		s_nxt.pri_oe = s_nxt.ctl0[C0_OE0];
		s_nxt.sec_oe = s_nxt.ctl0[C0_OE1];
	end

	// ****************************************************************
	// registers
	// ****************************************************************
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RSTN) begin
			s_r <= '{ctl0: C0_RESET, ctl1: C1_RESET, st: ST_OFF, default: '0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign O_PRDATA              = s_r.prdata;
	assign O_PREADY              = s_r.pready;
	assign O_PSLVERR             = s_r.pslverr;
	assign O_PRIMARY_DRIVE_OUT   = s_r.pri_out;
	assign O_PRIMARY_DRIVE_OE    = s_r.pri_oe;
	assign O_SECONDARY_DRIVE_OUT = s_r.sec_out;
	assign O_SECONDARY_DRIVE_OE  = s_r.sec_oe;

endmodule : cpwm_gen

/* shared/cpwm_pkg.sv */
// complementary pwm output generator: register map, field layout, timing constants
// assumes a 40 MHz core clock and an apb master with 32-bit data
package cpwm_pkg;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int unsigned CORE_CLK_HZ = 40_000_000;
	localparam int unsigned FAST_OSC_HZ = 8_000_000;
	// generator clock periods in core cycles; the fast oscillator one derived from the rates
	localparam int unsigned FAST_OSC_DIV = CORE_CLK_HZ / FAST_OSC_HZ;
	localparam int unsigned INSTR_DIV    = 4;
	localparam int unsigned SYS_DIV      = 1;
	localparam int unsigned DIV_W        = 4;

	// ****************************************************************
	// register offsets (byte addresses)
	// ****************************************************************
	localparam logic [7:0] OFS_CONTROL_0 = 8'h00;
	localparam logic [7:0] OFS_CONTROL_1 = 8'h04;
	localparam logic [7:0] OFS_DEADBAND  = 8'h08;
	localparam logic [7:0] OFS_BLANKING  = 8'h0C;
	localparam logic [7:0] OFS_PHASE     = 8'h10;
	localparam logic [7:0] OFS_STATUS    = 8'h14;

	// ****************************************************************
	// fields
	// ****************************************************************
	localparam int unsigned CNT_W   = 4;
	localparam int unsigned SEL_W   = 3;
	localparam int unsigned N_SRC   = 8;
	// control_0
	localparam int unsigned C0_EN      = 0;
	localparam int unsigned C0_OE0     = 1;
	localparam int unsigned C0_OE1     = 2;
	localparam int unsigned C0_POL0    = 3;
	localparam int unsigned C0_POL1    = 4;
	localparam int unsigned C0_CS_LO   = 5;
	localparam int unsigned C0_OVR0    = 7;
	localparam int unsigned C0_OVR1    = 8;
	localparam int unsigned C0_W       = 9;
	// control_1
	localparam int unsigned C1_RS_LO   = 0;
	localparam int unsigned C1_RSIM    = 3;
	localparam int unsigned C1_FS_LO   = 4;
	localparam int unsigned C1_FSIM    = 7;
	localparam int unsigned C1_W       = 8;
	// deadband / blanking: rise in low nibble, fall in high nibble
	localparam int unsigned NIB_RISE_LO = 0;
	localparam int unsigned NIB_FALL_LO = 4;
	localparam int unsigned NIB_W       = 8;

	// sources ored with the limit timer
	localparam logic [SEL_W-1:0] SRC_LIMIT_A = 3'h6;
	localparam logic [SEL_W-1:0] SRC_LIMIT_B = 3'h7;

	// gen_clock_select encodings
	localparam logic [1:0] CS_FAST_OSC = 2'h0;
	localparam logic [1:0] CS_INSTR    = 2'h1;
	localparam logic [1:0] CS_SYS      = 2'h2;

	localparam logic [C0_W-1:0] C0_RESET = 9'h000;
	localparam logic [C1_W-1:0] C1_RESET = 8'h00;
	localparam logic [31:0]     RD_ZERO  = 32'h0000_0000;

	// drive sequence, gray along off > phase > rise db > on > fall db
	typedef enum logic [2:0] {
		ST_OFF     = 3'h0,
		ST_PHASE   = 3'h1,
		ST_RISE_DB = 3'h3,
		ST_ON      = 3'h2,
		ST_FALL_DB = 3'h6
	} drive_state_e;

endpackage : cpwm_pkg

/* test/gate_drv_model.sv */
// gate driver seen at one generator pin
// assumes a pin left undriven floats with no pull
`timescale 1ns/10ps
module gate_drv_model (
	input  wire logic i_clk,
	input  wire logic i_out,
	input  wire logic i_oe,
	output logic      o_gate
);
	logic last_r;
	always_ff @(posedge i_clk) if (i_oe) last_r <= i_out;
	// floating pin shows the inverse, so a stale level never passes
	assign o_gate = i_oe ? i_out : ~last_r;
endmodule : gate_drv_model

/* test/cpwm_gen_asserts.sv */
// checker for cpwm_gen, bound to its ports
// assumes settings change only through completed apb writes
`timescale 1ns/10ps
module cpwm_gen_asserts
	import cpwm_pkg::*;
(
	input wire logic        I_CORE_CLK,
	input wire logic        I_RSTN,
	input wire logic        I_PSEL,
	input wire logic        I_PENABLE,
	input wire logic        I_PWRITE,
	input wire logic [7:0]  I_PADDR,
	input wire logic [31:0] I_PWDATA,
	input wire logic [31:0] O_PRDATA,
	input wire logic        O_PREADY,
	input wire logic        O_PSLVERR,
	input wire logic [7:0]  I_EVENT_SRC,
	input wire logic        I_LIMIT_TIMER,
	input wire logic        O_PRIMARY_DRIVE_OUT,
	input wire logic        O_PRIMARY_DRIVE_OE,
	input wire logic        O_SECONDARY_DRIVE_OUT,
	input wire logic        O_SECONDARY_DRIVE_OE
);
	// ********************
	// shadow of the settings
	// ********************
	logic [31:0] c0_r, c1_r, db_r, blk_r, ph_r, c0_d1, c0_d2;
	logic        wr, cfg_ok, zc, act0, act1, rsrc, fsrc;
	assign wr     = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE;
	// outputs switch on the same edge as the register; judge only settled settings
	assign cfg_ok = (c0_r == c0_d1) && (c0_d1 == c0_d2);
	assign act0   = O_PRIMARY_DRIVE_OUT ^ c0_r[C0_POL0];
	assign act1   = O_SECONDARY_DRIVE_OUT ^ c0_r[C0_POL1];
	assign zc     = cfg_ok && c0_r[C0_EN] && db_r[7:0] == 0 && blk_r[7:0] == 0 && ph_r[3:0] == 0;
	assign rsrc   = I_EVENT_SRC[c1_r[2:0]] | (c1_r[2] & c1_r[1] & I_LIMIT_TIMER);
	assign fsrc   = I_EVENT_SRC[c1_r[6:4]] | (c1_r[6] & c1_r[5] & I_LIMIT_TIMER);
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RSTN) begin
			{c0_r, c1_r, db_r, blk_r, ph_r, c0_d1, c0_d2} <= '0;
		end else begin
			if (wr && I_PADDR == OFS_CONTROL_0) c0_r <= I_PWDATA;
			if (wr && I_PADDR == OFS_CONTROL_1) c1_r <= I_PWDATA;
			if (wr && I_PADDR == OFS_DEADBAND) db_r <= I_PWDATA;
			if (wr && I_PADDR == OFS_BLANKING) blk_r <= I_PWDATA;
			if (wr && I_PADDR == OFS_PHASE) ph_r <= I_PWDATA;
			c0_d1 <= c0_r;
			c0_d2 <= c0_d1;
		end
	end
	default clocking cb @(posedge I_CORE_CLK); endclocking
	default disable iff (!I_RSTN);
	a_ready_wait: assert property (I_PSEL && I_PENABLE && !$past(I_PENABLE) |-> !O_PREADY ##1 O_PREADY)
		else $error("pready not in second access cycle");
	a_ready_pulse: assert property (O_PREADY |=> !O_PREADY) else $error("pready longer than one cycle");
	a_err_zero: assert property (O_PSLVERR |-> O_PREADY && (I_PWRITE || O_PRDATA == RD_ZERO))
		else $error("bad error response");
	a_oe_follow: assert property (cfg_ok |-> O_PRIMARY_DRIVE_OE == c0_r[C0_OE0] &&
		O_SECONDARY_DRIVE_OE == c0_r[C0_OE1]) else $error("output enable wrong");
	a_override_lvl: assert property (cfg_ok && !c0_r[C0_EN] |->
		O_PRIMARY_DRIVE_OUT == c0_r[C0_OVR0] && O_SECONDARY_DRIVE_OUT == c0_r[C0_OVR1])
		else $error("override level wrong");
	a_no_overlap: assert property (cfg_ok && c0_r[C0_EN] |-> !(act0 && act1))
		else $error("both outputs active");
	a_enable_state: assert property ($rose(c0_r[C0_EN]) |-> ##[1:2] (act1 && !act0))
		else $error("wrong state after enable");
	a_rise_sets: assert property (zc && !c1_r[C1_RSIM] && act1 && $rose(rsrc) |->
		##4 (act0 && !act1)) else $error("rise not on time");
	a_fall_clears: assert property (zc && !c1_r[C1_FSIM] && act0 && $fell(fsrc) |->
		##4 (act1 && !act0)) else $error("fall not on time");
	c_write: cover property (wr && I_PADDR == OFS_CONTROL_0);
	c_error: cover property (O_PSLVERR);
	c_primary: cover property ($rose(act0));
endmodule : cpwm_gen_asserts

bind cpwm_gen cpwm_gen_asserts i_chk (.I_CORE_CLK(I_CORE_CLK), .I_RSTN(I_RSTN), .I_PSEL(I_PSEL),
	.I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
	.O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .I_EVENT_SRC(I_EVENT_SRC),
	.I_LIMIT_TIMER(I_LIMIT_TIMER), .O_PRIMARY_DRIVE_OUT(O_PRIMARY_DRIVE_OUT),
	.O_PRIMARY_DRIVE_OE(O_PRIMARY_DRIVE_OE), .O_SECONDARY_DRIVE_OUT(O_SECONDARY_DRIVE_OUT),
	.O_SECONDARY_DRIVE_OE(O_SECONDARY_DRIVE_OE));

/* test/cpwm_gen_test.sv */
// self-checking bench for cpwm_gen: apb setup, then one task per scenario
// assumes gate_drv_model on both pins and the bound checker
`timescale 1ns/10ps
module cpwm_gen_test
	import cpwm_pkg::*;
;
	logic        clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00, src = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic        pready, pslverr, limit = 1'b0, out0, oe0, out1, oe1, gate0, gate1;
	int          n_mismatch = 0, num_checks = 0;
	always #12.5 clk = ~clk;
	cpwm_gen #(.FAST_DIV(FAST_OSC_DIV)) i_dut (.I_CORE_CLK(clk), .I_RSTN(rstn), .I_PSEL(psel),
		.I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
		.O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_EVENT_SRC(src),
		.I_LIMIT_TIMER(limit), .O_PRIMARY_DRIVE_OUT(out0), .O_PRIMARY_DRIVE_OE(oe0),
		.O_SECONDARY_DRIVE_OUT(out1), .O_SECONDARY_DRIVE_OE(oe1));
	gate_drv_model i_gate0 (.i_clk(clk), .i_out(out0), .i_oe(oe0), .o_gate(gate0));
	gate_drv_model i_gate1 (.i_clk(clk), .i_out(out1), .i_oe(oe1), .o_gate(gate1));
	// ********************
	// shared tasks
	// ********************
	task automatic stop_test;
		if (n_mismatch == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : stop_test
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		int k = 0;
		@(posedge clk);
		psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		#1;
		// look at pready settled before the edge that samples it
		while (pready !== 1'b1 && k < 50) begin
			@(posedge clk);
			#1;
			k++;
		end
		if (k >= 50) begin n_mismatch++; stop_test(); end
		rd = prdata; err = pslverr;
		@(posedge clk);
		psel <= 1'b0; penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] rd; logic err;
		apb(1'b1, a, d, rd, err);
	endtask : wr
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic experr);
		logic [31:0] rd; logic err;
		apb(1'b0, a, 32'h0, rd, err);
		check(rd, exp);
		check({31'h0, err}, {31'h0, experr});
	endtask : rdchk
	task automatic idle(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : idle
	// bounded wait for one pin, counting core cycles
	task automatic wait_gate(input logic sec, input logic lvl, output int n);
		n = 0;
		while (((sec ? gate1 : gate0) !== lvl) && n < 200) begin
			@(posedge clk); n++; #1;
		end
		if (n >= 200) begin n_mismatch++; stop_test(); end
	endtask : wait_gate
	task automatic step(input logic [7:0] v, input logic sec, input logic lvl, output int n);
		@(posedge clk); src <= v;
		wait_gate(sec, lvl, n);
	endtask : step
	task automatic in_rng(input int n, input int lo, input int hi);
		check({31'h0, n >= lo && n <= hi}, 32'h1);
	endtask : in_rng
	// ********************
	// scenarios
	// ********************
	task automatic t_regs;
		for (int i = 0; i < 6; i++) rdchk(8'(4 * i), RD_ZERO, 1'b0);
		wr(OFS_CONTROL_1, 32'hFFFF_FFFF);
		rdchk(OFS_CONTROL_1, 32'h0000_00FF, 1'b0);
		wr(8'h18, 32'hFFFF_FFFF);
		rdchk(8'h18, RD_ZERO, 1'b1);
	endtask : t_regs
	task automatic t_override;
		wr(OFS_CONTROL_0, 32'h0000_011E);
		idle(4);
		check({30'h0, gate0, gate1}, 32'h1);
		wr(OFS_CONTROL_0, 32'h0000_011C);
		idle(4);
		check({30'h0, oe0, oe1}, 32'h1);
	endtask : t_override
	task automatic t_single;
		int n;
		wr(OFS_CONTROL_1, 32'h0000_0022);
		wr(OFS_CONTROL_0, 32'h0000_0047);
		idle(4);
		check({30'h0, gate0, gate1}, 32'h1);
		step(8'h04, 1'b0, 1'b1, n);
		check(32'(n), 32'd3);
		check({31'h0, gate1}, 32'h0);
		idle(16);
		step(8'h00, 1'b0, 1'b0, n);
		check(32'(n), 32'd3);
		check({31'h0, gate1}, 32'h1);
		wr(OFS_CONTROL_0, 32'h0000_005F);
		idle(4);
		check({30'h0, gate0, gate1}, 32'h2);
	endtask : t_single
	task automatic t_delays;
		int div [3] = '{FAST_OSC_DIV, INSTR_DIV, SYS_DIV};
		int n;
		wr(OFS_PHASE, 32'h2);
		wr(OFS_DEADBAND, 32'h0000_0031);
		for (int cs = 0; cs < 3; cs++) begin
			wr(OFS_CONTROL_0, 32'h0000_0007 | (32'(cs) << C0_CS_LO));
			step(8'h04, 1'b1, 1'b0, n);
			in_rng(n, 3 + 2 * div[cs], 5 + 3 * div[cs]);
			wait_gate(1'b0, 1'b1, n);
			in_rng(n, div[cs] - 1, 2 * div[cs] + 1);
			idle(8);
			step(8'h00, 1'b0, 1'b0, n);
			in_rng(n, 3, 5);
			wait_gate(1'b1, 1'b1, n);
			in_rng(n, 3 * div[cs] - 1, 4 * div[cs] + 1);
			idle(8);
		end
		wr(OFS_PHASE, 32'h0);
		wr(OFS_DEADBAND, 32'h0);
	endtask : t_delays
	task automatic t_blank_limit;
		int n;
		wr(OFS_CONTROL_1, 32'h0000_0068);
		wr(OFS_BLANKING, 32'h0000_0040);
		step(8'h01, 1'b0, 1'b1, n);
		in_rng(n, 3, 5);
		@(posedge clk); limit <= 1'b1;
		idle(6);
		@(posedge clk); limit <= 1'b0;
		wait_gate(1'b0, 1'b0, n);
		in_rng(n, 3, 5);
		wait_gate(1'b0, 1'b1, n);
		in_rng(n, 4, 12);
		wr(OFS_CONTROL_1, 32'h0000_0060);
		@(posedge clk); src <= 8'h00; limit <= 1'b1;
		@(posedge clk); limit <= 1'b0;
		idle(2);
		@(posedge clk); src <= 8'h01;
		idle(30);
		check({30'h0, gate0, gate1}, 32'h1);
	endtask : t_blank_limit
	initial begin
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		t_regs();
		t_override();
		t_single();
		t_delays();
		t_blank_limit();
		stop_test();
	end
endmodule : cpwm_gen_test
